// ### hdl/brp_pkg.sv
package brp_pkg;
  localparam logic [7:0] FLAGS_ADDR      = 8'hda;
  localparam logic [7:0] PROT_ADDR       = 8'hdb;
  localparam logic [7:0] FLAGS_RESET     = 8'h00;
  localparam logic [7:0] FLAGS_USED_MASK = 8'hf2;
  localparam logic [7:0] PROT_RESET      = 8'h20;
  localparam int         BIT_CODE_LOCK   = 7;
  localparam int         BIT_EEPROM_LOCK = 6;
  localparam int         BIT_RAM_CLEAR   = 5;
  localparam int         BIT_EARLY_OSC   = 4;
  localparam int         BIT_AUTORUN     = 1;
  localparam int         PB_CODE_LOCK    = 7;
  localparam int         PB_DEBUG_OFF    = 6;
  localparam int         PB_EEPROM_LOCK  = 4;
  localparam logic [2:0] LEVEL_FACTORY   = 3'h1;
  localparam logic [2:0] LEVEL_USER      = 3'h3;
  localparam logic [2:0] LEVEL_RUN       = 3'h7;
  localparam int         RAM_WORDS       = 16;
  localparam logic [3:0] RAM_LAST        = 4'hf;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_LOAD  = 6'h02,
    ST_CLEAR = 6'h04,
    ST_LOCK  = 6'h08,
    ST_OPEN  = 6'h10,
    ST_DONE  = 6'h20
  } brp_state_t;
endpackage : brp_pkg

// ### hdl/brp_ram_clear.sv
`timescale 1ns/1ps
module brp_ram_clear (
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       start_i,
  output logic            busy_o,
  output logic            done_o,
  output logic [3:0]      addr_o,
  output logic            we_o
);
  import brp_pkg::*;
  logic [3:0] addr;
  logic       busy;
  logic       done;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr <= 4'h0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start_i && !busy) begin
        busy <= 1'b1;
        addr <= 4'h0;
      end else if (busy) begin
        if (addr == RAM_LAST) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          addr <= addr + 4'h1;
        end
      end
    end
  end
  assign busy_o = busy;
  assign done_o = done;
  assign addr_o = addr;
  assign we_o   = busy;
endmodule : brp_ram_clear

// ### hdl/brp_top.sv
`timescale 1ns/1ps
module brp_top
  import brp_pkg::*;
(
  input  wire logic       MCLK_I,
  input  wire logic       ARST_N_I,
  input  wire logic       BOOT_START_I,
  input  wire logic       RETEST_ENTRY_I,
  input  wire logic [2:0] LEVEL_I,
  input  wire logic [7:0] NVM_FLAGS_I,
  input  wire logic       COPY_DONE_I,
  input  wire logic       SFR_WR_I,
  input  wire logic       SFR_RD_I,
  input  wire logic [7:0] SFR_ADDR_I,
  input  wire logic [7:0] SFR_WDATA_I,
  output logic      [7:0] SFR_RDATA_O,
  output logic            OSC_ENABLE_O,
  output logic            COPY_REQ_O,
  output logic            RUN_USER_O,
  output logic            CODE_LOCK_O,
  output logic            EEPROM_LOCK_O,
  output logic            DEBUG_OPEN_O,
  output logic            BOOT_DONE_O,
  output logic [3:0]      RAM_ADDR_O,
  output logic            RAM_WE_O
);
  import brp_pkg::*;
  brp_state_t state;
  brp_state_t next_state;
  logic [7:0] flags;
  logic [7:0] prot;
  logic [7:0] prot_set;
  logic [7:0] rdata;
  logic       retest;
  logic       run_level;
  logic       clr_start;
  logic       clr_busy;
  logic       clr_done;
  logic       osc_en;
  logic       copy_req;
  logic       run_user;
  logic       dbg_open;
  logic       boot_done;

  assign run_level = (LEVEL_I == LEVEL_RUN);

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    next_state = state;
    clr_start  = 1'b0;
    case (state)
      ST_IDLE: begin
        if (BOOT_START_I) begin
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (retest && flags[BIT_RAM_CLEAR]) begin
          clr_start  = 1'b1;
          next_state = ST_CLEAR;
        end else if (retest) begin
          next_state = ST_LOCK;
        end else if (COPY_DONE_I || !copy_req) begin
          next_state = ST_DONE;
        end
      end
      ST_CLEAR: begin
        if (clr_done) begin
          next_state = ST_LOCK;
        end
      end
      ST_LOCK: begin
        next_state = ST_OPEN;
      end
      ST_OPEN: begin
        next_state = ST_DONE;
      end
      ST_DONE: begin
        next_state = ST_DONE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Flags are captured once at boot start; SFR writes to FLAGS_ADDR do not change them
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      flags  <= FLAGS_RESET;
      retest <= 1'b0;
    end else if (state == ST_IDLE && BOOT_START_I) begin
      flags  <= flags | (NVM_FLAGS_I & FLAGS_USED_MASK);
      retest <= RETEST_ENTRY_I && run_level;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      osc_en <= 1'b0;
    end else if (state == ST_IDLE && BOOT_START_I && NVM_FLAGS_I[BIT_EARLY_OSC]) begin
      osc_en <= 1'b1;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      copy_req <= 1'b0;
      run_user <= 1'b0;
    end else begin
      if (state == ST_IDLE && BOOT_START_I) begin
        copy_req <= (LEVEL_I == LEVEL_USER) && !RETEST_ENTRY_I;
      end else if (state == ST_LOAD && COPY_DONE_I) begin
        copy_req <= 1'b0;
      end
      if (state == ST_LOAD && next_state == ST_DONE && LEVEL_I == LEVEL_USER && !retest) begin
        run_user <= flags[BIT_AUTORUN];
      end
    end
  end

  // Boot and software set requests are merged so that neither loses a bit
  always_comb begin
    prot_set = 8'h00;
    if (state == ST_LOAD) begin
      prot_set[2:0] = LEVEL_I;
    end
    if (state == ST_LOCK) begin
      prot_set[PB_CODE_LOCK]   = flags[BIT_CODE_LOCK];
      prot_set[PB_EEPROM_LOCK] = flags[BIT_EEPROM_LOCK];
    end
    if (SFR_WR_I && SFR_ADDR_I == PROT_ADDR) begin
      prot_set = prot_set | (SFR_WDATA_I & 8'hdf);
    end
  end

  // Protection register: boot and software may only set bits
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      prot <= PROT_RESET;
    end else begin
      prot <= prot | prot_set;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      dbg_open  <= 1'b0;
      boot_done <= 1'b0;
    end else begin
      if (state == ST_OPEN && !prot[PB_DEBUG_OFF]) begin
        dbg_open <= 1'b1;
      end
      if (state == ST_DONE) begin
        boot_done <= 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rdata <= 8'h00;
    end else if (SFR_RD_I) begin
      if (SFR_ADDR_I == PROT_ADDR) begin
        rdata <= prot;
      end else if (SFR_ADDR_I == FLAGS_ADDR) begin
        rdata <= 8'h00;
      end else begin
        rdata <= 8'h00;
      end
    end
  end

  brp_ram_clear u_clear (
    .clk_i    (MCLK_I),
    .arst_n_i (ARST_N_I),
    .start_i  (clr_start),
    .busy_o   (clr_busy),
    .done_o   (clr_done),
    .addr_o   (RAM_ADDR_O),
    .we_o     (RAM_WE_O)
  );

  assign SFR_RDATA_O   = rdata;
  assign OSC_ENABLE_O  = osc_en;
  assign COPY_REQ_O    = copy_req;
  assign RUN_USER_O    = run_user;
  assign CODE_LOCK_O   = prot[PB_CODE_LOCK];
  assign EEPROM_LOCK_O = prot[PB_EEPROM_LOCK];
  assign DEBUG_OPEN_O  = dbg_open;
  assign BOOT_DONE_O   = boot_done;

  code_lock_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    (state == ST_LOCK && flags[BIT_CODE_LOCK]) |=> CODE_LOCK_O)
    else $error("code lock missing");
  eeprom_lock_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    (state == ST_LOCK && flags[BIT_EEPROM_LOCK]) |=> EEPROM_LOCK_O)
    else $error("eeprom lock missing");
  clear_first_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    $rose(dbg_open) |-> !clr_busy && (!flags[BIT_RAM_CLEAR] || $past(state, 3) != ST_LOAD))
    else $error("port opened during clear");
  early_osc_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    (state == ST_IDLE && BOOT_START_I && NVM_FLAGS_I[BIT_EARLY_OSC]) |=> OSC_ENABLE_O)
    else $error("oscillator not started");
  autorun_level_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    $rose(RUN_USER_O) |-> $past(LEVEL_I) == LEVEL_USER)
    else $error("autorun outside user level");
  sticky_prot_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    (prot & $past(prot)) == $past(prot))
    else $error("protection bit cleared");
  retest_gate_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    (state == ST_LOAD && !run_level) |=> state != ST_CLEAR && state != ST_LOCK)
    else $error("retest acted below run level");
  open_order_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    $rose(DEBUG_OPEN_O) |-> $past(state, 2) == ST_LOCK)
    else $error("port opened early");
  reserved_zero_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    (flags & ~FLAGS_USED_MASK) == 8'h00)
    else $error("reserved flag set");
endmodule : brp_top

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import brp_pkg::*;
  logic       MCLK_I = 1'b0;
  logic       ARST_N_I, BOOT_START_I, RETEST_ENTRY_I, COPY_DONE_I, SFR_WR_I, SFR_RD_I;
  logic [2:0] LEVEL_I;
  logic [7:0] NVM_FLAGS_I, SFR_ADDR_I, SFR_WDATA_I, SFR_RDATA_O;
  logic       OSC_ENABLE_O, COPY_REQ_O, RUN_USER_O, CODE_LOCK_O, EEPROM_LOCK_O;
  logic       DEBUG_OPEN_O, BOOT_DONE_O, RAM_WE_O, rd_d;
  logic [3:0] RAM_ADDR_O;
  logic [7:0] exp_q[$];
  logic [7:0] f, w;
  logic [2:0] lv[3] = '{LEVEL_FACTORY, LEVEL_USER, LEVEL_RUN};
  int         n_fail, check_count, cyc, we_n, seed = 53772;
  bit         cp;
  always #50 MCLK_I = ~MCLK_I;
  brp_top dut (.MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I), .BOOT_START_I(BOOT_START_I),
    .RETEST_ENTRY_I(RETEST_ENTRY_I), .LEVEL_I(LEVEL_I), .NVM_FLAGS_I(NVM_FLAGS_I),
    .COPY_DONE_I(COPY_DONE_I), .SFR_WR_I(SFR_WR_I), .SFR_RD_I(SFR_RD_I),
    .SFR_ADDR_I(SFR_ADDR_I), .SFR_WDATA_I(SFR_WDATA_I), .SFR_RDATA_O(SFR_RDATA_O),
    .OSC_ENABLE_O(OSC_ENABLE_O), .COPY_REQ_O(COPY_REQ_O), .RUN_USER_O(RUN_USER_O),
    .CODE_LOCK_O(CODE_LOCK_O), .EEPROM_LOCK_O(EEPROM_LOCK_O), .DEBUG_OPEN_O(DEBUG_OPEN_O),
    .BOOT_DONE_O(BOOT_DONE_O), .RAM_ADDR_O(RAM_ADDR_O), .RAM_WE_O(RAM_WE_O));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks=%0d fails=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic rst();
    ARST_N_I = 1'b0;
    repeat (16) @(negedge MCLK_I);
    ARST_N_I = 1'b1;
  endtask : rst
  task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge MCLK_I);
    SFR_WR_I = wr;
    SFR_RD_I = !wr;
    SFR_ADDR_I = a;
    SFR_WDATA_I = d;
    @(negedge MCLK_I);
    SFR_WR_I = 1'b0;
    SFR_RD_I = 1'b0;
  endtask : sfr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    sfr(1'b0, a, 8'h00);
  endtask : rd
  task automatic boot(input logic [2:0] l, input logic [7:0] fl, input logic rt);
    @(negedge MCLK_I);
    LEVEL_I = l;
    NVM_FLAGS_I = fl;
    RETEST_ENTRY_I = rt;
    BOOT_START_I = 1'b1;
    we_n = 0;
    cp = 1'b0;
    @(negedge MCLK_I);
    BOOT_START_I = 1'b0;
    for (int i = 0; i < 100 && !BOOT_DONE_O && !DEBUG_OPEN_O; i++) begin
      @(negedge MCLK_I);
      if (RAM_WE_O === 1'b1) check(RAM_ADDR_O, we_n[3:0]);
      we_n += int'(RAM_WE_O);
      COPY_DONE_I = COPY_REQ_O && !cp;
      cp |= COPY_REQ_O;
    end
    COPY_DONE_I = 1'b0;
  endtask : boot
  // Read data is registered on the edge that takes the strobe and checked at the next falling edge
  always @(posedge MCLK_I) rd_d <= SFR_RD_I;
  always @(negedge MCLK_I) if (rd_d === 1'b1) check(SFR_RDATA_O, exp_q.pop_front());
  always @(posedge MCLK_I) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    {BOOT_START_I, RETEST_ENTRY_I, COPY_DONE_I, SFR_WR_I, SFR_RD_I} = '0;
    {LEVEL_I, NVM_FLAGS_I, SFR_ADDR_I, SFR_WDATA_I} = '0;
    rst();
    rd(PROT_ADDR, PROT_RESET);
    sfr(1'b1, FLAGS_ADDR, 8'hff);
    rd(FLAGS_ADDR, 8'h00);
    rd(8'h55, 8'h00);
    w = $random(seed);
    sfr(1'b1, PROT_ADDR, w);
    rd(PROT_ADDR, PROT_RESET | w);
    sfr(1'b1, PROT_ADDR, 8'h00);
    rd(PROT_ADDR, PROT_RESET | w);
    // Autorun only at user level; copy happens at user level either way
    for (int k = 0; k < 6; k++) begin
      rst();
      f = $random(seed);
      f[1] = (k < 3);
      boot(lv[k % 3], f & FLAGS_USED_MASK, 1'b0);
      check(RUN_USER_O, f[1] && lv[k % 3] == LEVEL_USER);
      check(cp, lv[k % 3] == LEVEL_USER);
      check(OSC_ENABLE_O, f[4]);
      check(BOOT_DONE_O, 1'b1);
      rd(PROT_ADDR, PROT_RESET | lv[k % 3]);
    end
    rst();
    boot(LEVEL_RUN, 8'he0, 1'b1);
    check(DEBUG_OPEN_O, 1'b1);
    check(we_n, RAM_WORDS);
    check(CODE_LOCK_O, 1'b1);
    check(EEPROM_LOCK_O, 1'b1);
    rd(PROT_ADDR, 8'hb7);
    rst();
    boot(LEVEL_USER, 8'he0, 1'b1);
    check({CODE_LOCK_O, EEPROM_LOCK_O}, 2'b00);
    check(we_n, 0);
    repeat (3) @(negedge MCLK_I);
    stop_test();
  end
endmodule : tb
